/* rtl/ddb_core.sv */
// DDR DRAM device: command decode, bank state, bursts and APB status
`timescale 1ns/1ps
`default_nettype none
`include "ddb_defines.svh"
module ddb_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ddr_ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire ddb_pkg::ddb_bank_t bank_select,
    input wire ddb_pkg::ddb_addr_t addr,
    input wire ddb_pkg::ddb_word_t dq_i,
    output ddb_pkg::ddb_word_t dq_o,
    output logic dq_oe_n,
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe_n,
    input wire logic dm
);
    import ddb_pkg::*;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    // Link pins run on a foreign clock; all are sampled as one vector so that
    // command fields stay aligned with the sampled link clock edge.
    logic [30:0] pin_s1_q, pin_s2_q;
    logic ck_s3_q, dqs_s3_q;
    logic ck_s, cke_s, cs_n_s, dqs_s, dm_s;
    logic [2:0] rcw_s;
    ddb_bank_t ba_s;
    ddb_addr_t addr_s;
    ddb_word_t dq_s;
    logic ck_rise, lk_edge, dqs_edge;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            ck_s3_q <= 1'h0;
            dqs_s3_q <= 1'h0;
        end else begin
            pin_s1_q <= {ddr_ck, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, dq_i, dqs_i, dm};
            pin_s2_q <= pin_s1_q;
            ck_s3_q <= ck_s;
            dqs_s3_q <= dqs_s;
        end
    end
    assign {ck_s, cke_s, cs_n_s, rcw_s, ba_s, addr_s, dq_s, dqs_s, dm_s} = pin_s2_q;
    assign ck_rise = ck_s & ~ck_s3_q;
    assign lk_edge = ck_s ^ ck_s3_q;
    assign dqs_edge = dqs_s ^ dqs_s3_q;
    // -------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------
    ddb_pwr_e pwr_q, pwr_d;
    logic cmd_ok, cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_ref, cmd_mrs;
    logic [2:0] bl_code_q, bl_code_d, cl_code_q, cl_code_d, bl_mask, cl_half, bl_half;
    logic bt_q, bt_d;
    logic [10:0] col_in;
    logic ctrl_x4_q, ctrl_x4_d;
    assign cmd_ok = ck_rise & cke_s & ~cs_n_s & (pwr_q == DDB_PS_RUN);
    assign cmd_act = cmd_ok & (rcw_s == `DDB_RCW_ACT);
    assign cmd_rd = cmd_ok & (rcw_s == `DDB_RCW_READ);
    assign cmd_wr = cmd_ok & (rcw_s == `DDB_RCW_WRITE);
    assign cmd_pre = cmd_ok & (rcw_s == `DDB_RCW_PRE);
    assign cmd_ref = cmd_ok & (rcw_s == `DDB_RCW_REF);
    assign cmd_mrs = cmd_ok & (rcw_s == `DDB_RCW_MRS);
    always_comb begin
        case (bl_code_q)
            `DDB_BL2: bl_mask = `DDB_MASK_BL2;
            `DDB_BL4: bl_mask = `DDB_MASK_BL4;
            default: bl_mask = `DDB_MASK_BL8;
        endcase
        // Latency counted in link half cycles so that 1.5 and 2.5 are exact
        case (cl_code_q)
            `DDB_CL15: cl_half = `DDB_HALF_CL15;
            `DDB_CL25: cl_half = `DDB_HALF_CL25;
            default: cl_half = `DDB_HALF_CL2;
        endcase
        bl_half = {1'h0, bl_mask[2:1]} + 3'h1;
    end
    assign col_in = {ctrl_x4_q & addr_s[`DDB_COL_HI_BIT], addr_s[9:0]};
    // -------------------------------------------------------------------
    // Banks
    // -------------------------------------------------------------------
    wire [3:0] bank_open;
    wire [12:0] bank_row [4];
    logic wr_close;
    ddb_bank_t wr_bank_q, wr_bank_d;
    for (genvar b = 0; b < 4; b++) begin : g_bank
        logic open_q, open_d;
        ddb_addr_t row_q, row_d;
        logic [2:0] cnt_q, cnt_d;
        wire hit = (ba_s == ddb_bank_t'(b));
        always_comb begin
            open_d = open_q;
            row_d = row_q;
            cnt_d = cnt_q;
            if (ck_rise && cnt_q != 3'h0) begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h1) begin
                    open_d = 1'h0;
                end
            end
            if (wr_close && wr_bank_q == ddb_bank_t'(b)) begin
                open_d = 1'h0;
            end
            if (cmd_pre && (addr_s[`DDB_AP_BIT] || hit)) begin
                open_d = 1'h0;
            end
            if (cmd_act && hit) begin
                open_d = 1'h1;
                row_d = addr_s;
            end
            if (cmd_rd && hit && addr_s[`DDB_AP_BIT]) begin
                cnt_d = bl_half;
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                open_q <= 1'h0;
                row_q <= '0;
                cnt_q <= 3'h0;
            end else begin
                open_q <= open_d;
                row_q <= row_d;
                cnt_q <= cnt_d;
            end
        end
        assign bank_open[b] = open_q;
        assign bank_row[b] = row_q;
        ap_close_a: assert property (ck_rise && cnt_q == 3'h1 && !(cmd_act && hit) |=> !open_q)
            else $error("Autoclose read left the bank open");
        ap_load_a: assert property (cmd_rd && hit && addr_s[`DDB_AP_BIT] |=> cnt_q == $past(bl_half))
            else $error("Autoclose delay not half the burst");
    end
    // -------------------------------------------------------------------
    // Read burst pipeline
    // -------------------------------------------------------------------
    // One slot per link half cycle; a read or a stop token enters at the slot
    // that makes it emerge exactly one latency later.
    ddb_slot_s slot_q [`DDB_SLOTS], slot_d [`DDB_SLOTS];
    logic rd_act_q, rd_act_d;
    ddb_bank_t rd_bank_q, rd_bank_d;
    ddb_col_t rd_col_q, rd_col_d, rd_idx_q, rd_idx_d, rd_ord;
    ddb_word_t dq_o_q, dq_o_d;
    logic dq_oe_n_q, dq_oe_n_d, dqs_o_q, dqs_o_d, dqs_oe_n_q, dqs_oe_n_d;
    ddb_word_t mem_q [32], mem_d [32];
    ddb_burst_order u_rd_order (
        .start(rd_col_d),
        .idx(rd_idx_d),
        .mask(bl_mask),
        .interleave(bt_q),
        .col(rd_ord)
    );
    always_comb begin
        slot_d = slot_q;
        rd_act_d = rd_act_q;
        rd_bank_d = rd_bank_q;
        rd_col_d = rd_col_q;
        rd_idx_d = rd_idx_q;
        if (lk_edge) begin
            for (int i = 0; i < `DDB_SLOTS - 1; i++) begin
                slot_d[i] = slot_q[i + 1];
            end
            slot_d[`DDB_SLOTS - 1] = '0;
            if (rd_act_q) begin
                rd_idx_d = rd_idx_q + 3'h1;
                if (rd_idx_q == bl_mask) begin
                    rd_act_d = 1'h0;
                end
            end
            if (slot_q[0].valid && slot_q[0].stop) begin
                if (slot_q[0].all || slot_q[0].bank == rd_bank_q) begin
                    rd_act_d = 1'h0;
                end
            end else if (slot_q[0].valid) begin
                rd_act_d = 1'h1;
                rd_bank_d = slot_q[0].bank;
                rd_col_d = slot_q[0].col;
                rd_idx_d = 3'h0;
            end
        end
        if (cmd_rd || cmd_pre) begin
            slot_d[cl_half - 3'h1] = '{1'h1, cmd_pre, addr_s[`DDB_AP_BIT], ba_s, addr_s[2:0]};
        end
        dq_oe_n_d = ~rd_act_d;
        dqs_oe_n_d = ~rd_act_d;
        dqs_o_d = rd_act_d & ~rd_idx_d[0];
        dq_o_d = rd_act_d ? mem_q[{rd_bank_d, rd_ord}] : 8'h00;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DDB_SLOTS; i++) begin
                slot_q[i] <= '0;
            end
            rd_act_q <= 1'h0;
            rd_bank_q <= 2'h0;
            rd_col_q <= 3'h0;
            rd_idx_q <= 3'h0;
            dq_o_q <= 8'h00;
            dq_oe_n_q <= 1'h1;
            dqs_o_q <= 1'h0;
            dqs_oe_n_q <= 1'h1;
        end else begin
            slot_q <= slot_d;
            rd_act_q <= rd_act_d;
            rd_bank_q <= rd_bank_d;
            rd_col_q <= rd_col_d;
            rd_idx_q <= rd_idx_d;
            dq_o_q <= dq_o_d;
            dq_oe_n_q <= dq_oe_n_d;
            dqs_o_q <= dqs_o_d;
            dqs_oe_n_q <= dqs_oe_n_d;
        end
    end
    assign dq_o = dq_o_q;
    assign dq_oe_n = dq_oe_n_q;
    assign dqs_o = dqs_o_q;
    assign dqs_oe_n = dqs_oe_n_q;
    // -------------------------------------------------------------------
    // Write burst capture and storage
    // -------------------------------------------------------------------
    logic wr_act_q, wr_act_d, wr_ap_q, wr_ap_d, wr_we;
    ddb_col_t wr_col_q, wr_col_d, wr_idx_q, wr_idx_d, wr_ord;
    logic [4:0] wr_addr;
    ddb_burst_order u_wr_order (
        .start(wr_col_q),
        .idx(wr_idx_q),
        .mask(bl_mask),
        .interleave(bt_q),
        .col(wr_ord)
    );
    assign wr_addr = {wr_bank_q, wr_ord};
    always_comb begin
        wr_act_d = wr_act_q;
        wr_bank_d = wr_bank_q;
        wr_col_d = wr_col_q;
        wr_idx_d = wr_idx_q;
        wr_ap_d = wr_ap_q;
        wr_we = 1'h0;
        wr_close = 1'h0;
        // Only a rising strobe may latch the first word, so a late preamble is not data
        if (dqs_edge && wr_act_q && (wr_idx_q != 3'h0 || dqs_s)) begin
            wr_we = ~dm_s;
            wr_idx_d = wr_idx_q + 3'h1;
            if (wr_idx_q == bl_mask) begin
                wr_act_d = 1'h0;
                wr_close = wr_ap_q;
            end
        end
        if (cmd_wr) begin
            wr_act_d = 1'h1;
            wr_bank_d = ba_s;
            wr_col_d = addr_s[2:0];
            wr_idx_d = 3'h0;
            wr_ap_d = addr_s[`DDB_AP_BIT];
        end
        mem_d = mem_q;
        if (wr_we) begin
            mem_d[wr_addr] = dq_s;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_q <= 1'h0;
            wr_bank_q <= 2'h0;
            wr_col_q <= 3'h0;
            wr_idx_q <= 3'h0;
            wr_ap_q <= 1'h0;
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            wr_act_q <= wr_act_d;
            wr_bank_q <= wr_bank_d;
            wr_col_q <= wr_col_d;
            wr_idx_q <= wr_idx_d;
            wr_ap_q <= wr_ap_d;
            mem_q <= mem_d;
        end
    end
    // -------------------------------------------------------------------
    // Mode, refresh, power state and APB
    // -------------------------------------------------------------------
    logic [12:0] ref_row_q, ref_row_d;
    logic [10:0] last_col_q, last_col_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, status;
    always_comb begin
        pwr_d = pwr_q;
        bl_code_d = bl_code_q;
        bt_d = bt_q;
        cl_code_d = cl_code_q;
        ref_row_d = ref_row_q;
        last_col_d = last_col_q;
        ctrl_x4_d = ctrl_x4_q;
        case (pwr_q)
            DDB_PS_RUN: begin
                if (ck_rise && !cke_s) begin
                    pwr_d = (!cs_n_s && rcw_s == `DDB_RCW_REF) ? DDB_PS_SELF : DDB_PS_PDOWN;
                end
            end
            DDB_PS_PDOWN, DDB_PS_SELF: begin
                if (cke_s) begin
                    pwr_d = DDB_PS_RUN;
                end
            end
            default: pwr_d = DDB_PS_RUN;
        endcase
        if (cmd_ref) begin
            ref_row_d = ref_row_q + 13'h1;
        end
        if (cmd_mrs && ba_s == 2'h0) begin
            bl_code_d = addr_s[`DDB_BL_MSB:`DDB_BL_LSB];
            bt_d = addr_s[`DDB_BT_BIT];
            cl_code_d = addr_s[`DDB_CL_MSB:`DDB_CL_LSB];
        end
        if (cmd_rd || cmd_wr) begin
            last_col_d = col_in;
        end
        status = 32'h0;
        status[`DDB_ST_OPEN_LSB +: 4] = bank_open;
        status[`DDB_ST_PDOWN] = (pwr_q == DDB_PS_PDOWN);
        status[`DDB_ST_SELF] = (pwr_q == DDB_PS_SELF);
        status[`DDB_ST_BL_LSB +: 3] = bl_code_q;
        status[`DDB_ST_BT] = bt_q;
        status[`DDB_ST_CL_LSB +: 3] = cl_code_q;
        // Answer is prepared in the setup cycle so pready can come from a flop
        prdata_d = 32'h0;
        pready_d = psel & ~penable;
        pslverr_d = 1'h0;
        if (psel && !penable) begin
            case (paddr)
                `DDB_OFS_CTRL: prdata_d[`DDB_CTRL_X4] = ctrl_x4_q;
                `DDB_OFS_STATUS: prdata_d = status;
                `DDB_OFS_REFROW: prdata_d = {19'h0, ref_row_q};
                `DDB_OFS_COLUMN: prdata_d = {21'h0, last_col_q};
                default: begin
                    if (paddr[7:4] == `DDB_ROW_PAGE && paddr[1:0] == 2'h0) begin
                        prdata_d = {19'h0, bank_row[paddr[3:2]]};
                    end else begin
                        pslverr_d = 1'h1;
                    end
                end
            endcase
        end
        if (psel && penable && pready_q && pwrite && paddr == `DDB_OFS_CTRL) begin
            ctrl_x4_d = pwdata[`DDB_CTRL_X4];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= DDB_PS_RUN;
            bl_code_q <= `DDB_RST_BL;
            bt_q <= `DDB_RST_BT;
            cl_code_q <= `DDB_RST_CL;
            ref_row_q <= 13'h0;
            last_col_q <= 11'h0;
            ctrl_x4_q <= 1'h0;
            prdata_q <= 32'h0;
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
        end else begin
            pwr_q <= pwr_d;
            bl_code_q <= bl_code_d;
            bt_q <= bt_d;
            cl_code_q <= cl_code_d;
            ref_row_q <= ref_row_d;
            last_col_q <= last_col_d;
            ctrl_x4_q <= ctrl_x4_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    act_open_a: assert property (cmd_act |=> bank_open[$past(ba_s)] && bank_row[$past(ba_s)] == $past(addr_s))
        else $error("Activate did not open the bank");
    pre_all_a: assert property (cmd_pre && addr_s[`DDB_AP_BIT] |=> bank_open == 4'h0)
        else $error("Precharge all left a bank open");
    rd_first_a: assert property (lk_edge && slot_q[0].valid && !slot_q[0].stop |=> !dq_oe_n_q && rd_idx_q == 3'h0)
        else $error("Read data did not start at latency");
    burst_end_a: assert property (lk_edge && rd_act_q && rd_idx_q == bl_mask && !slot_q[0].valid |=> dq_oe_n_q)
        else $error("Read burst ran past its length");
    rd_restart_a: assert property (lk_edge && rd_act_q && slot_q[0].valid && !slot_q[0].stop |=> rd_col_q == $past(slot_q[0].col))
        else $error("Interrupting read did not restart the burst");
    pre_stop_a: assert property (lk_edge && slot_q[0].valid && slot_q[0].stop && slot_q[0].bank == rd_bank_q |=> dq_oe_n_q [*2])
        else $error("Precharge did not stop read data");
    col_pick_a: assert property (cmd_rd || cmd_wr |=> last_col_q == $past(col_in))
        else $error("Start column decoded wrongly");
    wr_store_a: assert property (wr_we |=> mem_q[$past(wr_addr)] == $past(dq_s))
        else $error("Write word not stored");
    wra_close_a: assert property (wr_close && !cmd_act |=> !bank_open[$past(wr_bank_q)])
        else $error("Autoclose write left the bank open");
    ref_row_a: assert property (cmd_ref |=> ref_row_q == $past(ref_row_q) + 13'h1)
        else $error("Refresh row did not advance");
    mrs_hold_a: assert property (!cmd_mrs |=> $stable(bl_code_q) && $stable(bt_q) && $stable(cl_code_q))
        else $error("Mode changed without mode_register_set");
    cs_nop_a: assert property (ck_rise && cs_n_s |=> $stable(ref_row_q) && $stable(last_col_q))
        else $error("Deselected command had an effect");
endmodule
`default_nettype wire

/* rtl/ddb_defines.svh */
// Constants for the DDR bank command timing block
`ifndef DDB_DEFINES_SVH
`define DDB_DEFINES_SVH
// -------------------------------------------------------------------------
// Contract
// - Four independent banks; activate opens one with bank select and row.
// - Precharge closes the selected bank, or all banks with the option bit.
// - Read data starts after the latency, then burst_length-1 ordered words.
// - Start column is A11,A9-A0 in x4 mode, A9-A0 in x8 mode.
// - Read with autoclose closes the bank burst_length/2 cycles later.
// - Write words latch on strobe edges, first 0.75 to 1.25 cycles later.
// - Write with autoclose closes the bank after the last word.
// - A new read cuts a running read burst short, one cycle apart.
// - Precharge to the read bank stops data one latency later.
// - Refresh rows are counted inside; all four banks refresh together.
// - Burst length and order are held until the next mode_register_set.
// -------------------------------------------------------------------------
`define DDB_RCW_ACT 3'h3
`define DDB_RCW_READ 3'h5
`define DDB_RCW_WRITE 3'h4
`define DDB_RCW_PRE 3'h2
`define DDB_RCW_REF 3'h1
`define DDB_RCW_MRS 3'h0
`define DDB_AP_BIT 10
`define DDB_COL_HI_BIT 11
`define DDB_BL_MSB 2
`define DDB_BL_LSB 0
`define DDB_BT_BIT 3
`define DDB_CL_MSB 6
`define DDB_CL_LSB 4
`define DDB_BL2 3'h1
`define DDB_BL4 3'h2
`define DDB_CL15 3'h5
`define DDB_CL25 3'h6
`define DDB_HALF_CL15 3'h3
`define DDB_HALF_CL2 3'h4
`define DDB_HALF_CL25 3'h5
`define DDB_MASK_BL2 3'h1
`define DDB_MASK_BL4 3'h3
`define DDB_MASK_BL8 3'h7
`define DDB_RST_BL 3'h3
`define DDB_RST_BT 1'h0
`define DDB_RST_CL 3'h2
`define DDB_SLOTS 6
`define DDB_OFS_CTRL 8'h00
`define DDB_OFS_STATUS 8'h04
`define DDB_OFS_REFROW 8'h08
`define DDB_OFS_COLUMN 8'h0c
`define DDB_ROW_PAGE 4'h1
`define DDB_CTRL_X4 0
`define DDB_ST_OPEN_LSB 0
`define DDB_ST_PDOWN 4
`define DDB_ST_SELF 5
`define DDB_ST_BL_LSB 8
`define DDB_ST_BT 11
`define DDB_ST_CL_LSB 12
`endif

/* rtl/ddb_pkg.sv */
// Types for the DDR bank command timing block
package ddb_pkg;
    typedef logic [7:0] ddb_word_t;
    typedef logic [1:0] ddb_bank_t;
    typedef logic [12:0] ddb_addr_t;
    typedef logic [2:0] ddb_col_t;
    typedef enum logic [2:0] {
        DDB_PS_RUN = 3'h1,
        DDB_PS_PDOWN = 3'h2,
        DDB_PS_SELF = 3'h4
    } ddb_pwr_e;
    typedef struct packed {
        logic valid;
        logic stop;
        logic all;
        ddb_bank_t bank;
        ddb_col_t col;
    } ddb_slot_s;
endpackage

/* rtl/ddb_burst_order.sv */
// Column walk inside a burst, sequential or interleaved
`timescale 1ns/1ps
`default_nettype none
module ddb_burst_order (
    input wire ddb_pkg::ddb_col_t start,
    input wire ddb_pkg::ddb_col_t idx,
    input wire logic [2:0] mask,
    input wire logic interleave,
    output ddb_pkg::ddb_col_t col
);
    import ddb_pkg::*;
    ddb_col_t walk;
    always_comb begin
        walk = interleave ? (start ^ idx) : ddb_col_t'(start + idx);
        // Bits above the burst length stay those of the start column
        col = (start & ~mask) | (walk & mask);
    end
endmodule
`default_nettype wire

/* tb/ddb_ctrl_model.sv */
// Controller model: free-running link clock, commands and write strobe
`timescale 1ns/1ps
`default_nettype none
`include "ddb_defines.svh"
module ddb_ctrl_model (
    input wire logic clk,
    output logic ddr_ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output ddb_pkg::ddb_bank_t bank_select,
    output ddb_pkg::ddb_addr_t addr,
    output ddb_pkg::ddb_word_t dq_i,
    output logic dqs_i,
    output logic dm,
    input wire ddb_pkg::ddb_word_t dq_o,
    input wire logic dq_oe_n,
    input wire logic dqs_o,
    input wire logic dqs_oe_n
);
    import ddb_pkg::*;
    logic drv = 1'b0;
    logic dqs_q = 1'b0;
    ddb_word_t dq_q = 8'h00;
    // Released lines show the inverse of their last value, never a stale copy
    assign dq_i = !dq_oe_n ? dq_o : (drv ? dq_q : ~dq_q);
    assign dqs_i = !dqs_oe_n ? dqs_o : (drv ? dqs_q : ~dqs_q);
    initial begin
        ddr_ck = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        {cke, dm, bank_select, addr} = {1'b1, 1'b0, 15'h0};
        // Link clock runs free, out of phase with clk, starting well after reset
        #1030;
        forever #400 ddr_ck = ~ddr_ck;
    end
    // Two link cycles per command: far above every spacing the device relies on
    task automatic issue(input logic [2:0] code, input ddb_bank_t b, input ddb_addr_t a);
        @(negedge ddr_ck);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, code};
        bank_select <= b;
        addr <= a;
        @(negedge ddr_ck);
        @(posedge clk);
        cs_n <= 1'b1;
        @(posedge ddr_ck);
    endtask
    // Clock enable low at a rise sleeps; chip select low with refresh code picks self refresh
    task automatic doze(input logic en, input logic deep);
        @(negedge ddr_ck);
        @(posedge clk);
        cke <= ~en;
        {cs_n, ras_n, cas_n, we_n} <= {~deep, `DDB_RCW_REF};
        // More than a link cycle passes before the next command after wake-up
        @(negedge ddr_ck);
        @(posedge clk);
        cs_n <= 1'b1;
        @(posedge ddr_ck);
    endtask
    // Strobe half period is a full link cycle so data is stable around each edge
    task automatic write2(input ddb_bank_t b, input ddb_addr_t a, input ddb_word_t d0, input ddb_word_t d1);
        @(posedge clk);
        drv <= 1'b1;
        dqs_q <= 1'b0;
        dq_q <= d0;
        issue(`DDB_RCW_WRITE, b, a);
        @(posedge clk);
        dqs_q <= 1'b1;
        repeat (4) @(posedge clk);
        dq_q <= d1;
        repeat (4) @(posedge clk);
        dqs_q <= 1'b0;
        repeat (4) @(posedge clk);
        drv <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench: register table over APB, then bank commands through the model
`timescale 1ns/1ps
`default_nettype none
`include "ddb_defines.svh"
module tb_top;
    import ddb_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ddr_ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_i, dqs_o, dqs_oe_n, dm;
    ddb_bank_t bank_select;
    ddb_addr_t addr;
    ddb_word_t dq_i, dq_o;
    int failures = 0;
    int samples_checked = 0;
    // {write, address, write data, expected read data, expected error}
    logic [73:0] rows [0:6] = '{{1'b0, 8'h04, 32'h0, 32'h2300, 1'b0}, {1'b1, 8'h00, 32'h1, 32'h0, 1'b0},
        {1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, {1'b1, 8'h04, 32'hffff, 32'h0, 1'b0},
        {1'b0, 8'h04, 32'h0, 32'h2300, 1'b0}, {1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h02, 32'h0, 32'h0, 1'b1}};
    ddb_core dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ddr_ck,
        .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .addr, .dq_i, .dq_o, .dq_oe_n, .dqs_i, .dqs_o, .dqs_oe_n, .dm);
    ddb_ctrl_model u_ctrl (.clk, .ddr_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .addr, .dq_i, .dqs_i,
        .dm, .dq_o, .dq_oe_n, .dqs_o, .dqs_oe_n);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    // Words stand one link half period: sample each in its middle
    task automatic rd2(input ddb_bank_t b, input ddb_addr_t a, input ddb_word_t e0, input ddb_word_t e1);
        u_ctrl.issue(`DDB_RCW_READ, b, a);
        while (dq_oe_n !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk(32'({dqs_o, dq_o}), 32'({1'b1, e0}));
        repeat (4) @(posedge clk);
        chk(32'({dqs_o, dq_o}), 32'({1'b0, e1}));
        repeat (4) @(posedge clk);
        chk(32'(dq_oe_n), 32'h1);
    endtask
    task automatic status(input logic [31:0] exp);
        // Bank state settles a few cycles after the link edge that changes it
        repeat (2) @(posedge clk);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, exp);
    endtask
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        end_sim;
    end
    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clk);
        chk(32'({pready, dq_oe_n, dqs_oe_n}), 32'h3);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
            if (!rows[i][73]) chk(rd, rows[i][32:1]);
            chk(32'(err), 32'(rows[i][0]));
        end
        // Mode register set: burst of two, sequential, latency two
        u_ctrl.issue(3'h0, 2'h0, 13'h0021);
        u_ctrl.issue(`DDB_RCW_ACT, 2'h1, 13'h0005);
        u_ctrl.issue(`DDB_RCW_ACT, 2'h2, 13'h0007);
        status(32'h2106);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h5);
        u_ctrl.write2(2'h1, 13'h0001, 8'ha5, 8'h3c);
        // Start column 1 wraps inside the pair, so column 0 holds the second word
        rd2(2'h1, 13'h0a00, 8'h3c, 8'ha5);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h600);
        u_ctrl.issue(`DDB_RCW_READ, 2'h2, 13'h0400);
        status(32'h2102);
        u_ctrl.issue(`DDB_RCW_ACT, 2'h3, 13'h0009);
        u_ctrl.issue(`DDB_RCW_PRE, 2'h1, 13'h0000);
        status(32'h2108);
        u_ctrl.issue(`DDB_RCW_PRE, 2'h0, 13'h0400);
        u_ctrl.issue(3'h0, 2'h1, 13'h0032);
        status(32'h2100);
        u_ctrl.doze(1'b1, 1'b0);
        status(32'h2110);
        u_ctrl.doze(1'b0, 1'b0);
        u_ctrl.doze(1'b1, 1'b1);
        status(32'h2120);
        u_ctrl.doze(1'b0, 1'b0);
        u_ctrl.issue(`DDB_RCW_REF, 2'h0, 13'h0000);
        u_ctrl.issue(`DDB_RCW_REF, 2'h0, 13'h0000);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h2);
        // Burst of eight, interleaved: a precharge two link cycles in cuts it at four words
        u_ctrl.issue(`DDB_RCW_MRS, 2'h0, 13'h002b);
        u_ctrl.issue(`DDB_RCW_ACT, 2'h1, 13'h0005);
        u_ctrl.issue(`DDB_RCW_READ, 2'h1, 13'h0001);
        u_ctrl.issue(`DDB_RCW_PRE, 2'h1, 13'h0000);
        chk(32'(dq_oe_n), 32'h0);
        repeat (16) @(posedge clk);
        chk(32'(dq_oe_n), 32'h1);
        end_sim;
    end
endmodule
`default_nettype wire
